// *** inc/ir_pin_pkg.sv ***
/*
  constants shared by the infrared controller pin logic: bus widths and
  the reset levels of the transmit, interrupt, aux, shutdown, data and address outputs. assumes one 125 MHz clock.
*/
package ir_pin_pkg;
  localparam int BUS_DATA_W = 16;
  localparam int BUS_ADDR_W = 4;
  localparam logic TX_RESET_LVL = 1'b0;
  localparam logic RC_RESET_LVL = 1'b0;
  localparam logic IRQ_N_RESET_LVL = 1'b1;
  localparam logic AUX_RESET_LVL = 1'b0;
  localparam logic SHUTDOWN_RESET_LVL = 1'b1;
  localparam logic [BUS_DATA_W-1:0] RDATA_RESET = 16'h0000;
  localparam logic [BUS_ADDR_W-1:0] ADDR_RESET = 4'h0;
endpackage : ir_pin_pkg

// *** inc/tx_route_if.sv ***
/*
  carrier between the pin port top and its transmit router: route
  configuration, source signals and the two routed transmit levels.
  assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface tx_route_if;
  logic remote_enable;
  logic remote_route_select;
  logic passthrough_mode;
  logic link_sig;
  logic remote_sig;
  logic ext_ir;
  logic suspend;
  logic ir_transmit;
  logic remote_tx;
  modport ctrl (
    output remote_enable, remote_route_select, passthrough_mode,
    output link_sig, remote_sig, ext_ir, suspend,
    input ir_transmit, remote_tx
  );
  modport router (
    input remote_enable, remote_route_select, passthrough_mode,
    input link_sig, remote_sig, ext_ir, suspend,
    output ir_transmit, remote_tx
  );
endinterface : tx_route_if
`default_nettype wire

// *** core/tx_router.sv ***
/*
  routes the link or remote-control signal, or the external infrared
  input in pass-through, onto the two transmit pins, registered.
  assumes synchronous reset, active high, from the top.
*/
`timescale 1ns/100ps
`default_nettype none
module tx_router (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  tx_route_if.router rt
);
  import ir_pin_pkg::*;

  logic tx_r;
  logic tx_nxt;
  logic rc_r;
  logic rc_nxt;
  logic src_rc;

  always_comb
  begin
    src_rc = rt.passthrough_mode ? rt.ext_ir : rt.remote_sig;
    tx_nxt = 1'b0;
    rc_nxt = 1'b0;
    if (!rt.suspend)
    begin
      if (!rt.remote_enable)
      begin
        tx_nxt = rt.passthrough_mode ? rt.ext_ir : rt.link_sig;
      end
      else if (rt.remote_route_select)
      begin
        tx_nxt = src_rc;
      end
      else
      begin
        rc_nxt = src_rc;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      tx_r <= TX_RESET_LVL;
      rc_r <= RC_RESET_LVL;
    end
    else
    begin
      tx_r <= tx_nxt;
      rc_r <= rc_nxt;
    end
  end

  assign rt.ir_transmit = tx_r;
  assign rt.remote_tx = rc_r;

  tx_link_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !rt.remote_enable && !rt.passthrough_mode && !rt.suspend
    |=> rt.ir_transmit == $past(rt.link_sig) && !rt.remote_tx)
    else $error("transmit pin does not follow link signal");
  rc_route_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    rt.remote_enable && !rt.remote_route_select && !rt.passthrough_mode && !rt.suspend
    |=> rt.remote_tx == $past(rt.remote_sig) && !rt.ir_transmit)
    else $error("remote pin does not follow remote signal");
  passthrough_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    rt.passthrough_mode && rt.remote_enable && rt.remote_route_select && !rt.suspend
    |=> rt.ir_transmit == $past(rt.ext_ir))
    else $error("external input not passed to transmit pin");
  tx_reset_a: assert property (@(posedge sys_clk_in)
    reset_in |=> !rt.ir_transmit && !rt.remote_tx)
    else $error("transmit pins not low after reset");
endmodule : tx_router
`default_nettype wire

// *** core/ir_pin_port.sv ***
/*
  pin-level logic of an infrared link controller: asynchronous-style
  host port turned into one-cycle register strobes, two interrupt pins,
  transmit routing, power-down and post-reset pin levels.
  assumes every pin already synchronous to sys_clk_in (125 MHz) and an
  internal register file answering reg_rdata_in in the cycle the read strobe pin goes active, one cycle before reg_rd_out.
*/
`timescale 1ns/100ps
`default_nettype none
module ir_pin_port #(
  parameter int DATA_W = ir_pin_pkg::BUS_DATA_W,
  parameter int ADDR_W = ir_pin_pkg::BUS_ADDR_W
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic power_down_n_in,
  input wire logic cs_n_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_out,
  output logic [ADDR_W-1:0] reg_addr_out,
  output logic [DATA_W-1:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [DATA_W-1:0] reg_rdata_in,
  input wire logic link_irq_cond_in,
  input wire logic remote_irq_cond_in,
  output logic link_irq_n_out,
  output logic remote_irq_n_out,
  input wire logic remote_enable_in,
  input wire logic remote_route_select_in,
  input wire logic passthrough_mode_in,
  input wire logic link_tx_in,
  input wire logic remote_sig_in,
  input wire logic external_ir_in,
  input wire logic ir_receive_in,
  output logic ir_receive_out,
  output logic ir_transmit_out,
  output logic remote_tx_out,
  input wire logic aux_control_in,
  output logic aux_control_out,
  input wire logic module_on_in,
  output logic module_shutdown_out,
  output logic wait_state_out
);
  import ir_pin_pkg::*;

  if (DATA_W != BUS_DATA_W || ADDR_W != BUS_ADDR_W)
  begin : g_width_check
    $error("host bus must be 16 data bits and 4 address bits");
  end

  logic suspend;
  logic rd_act;
  logic wr_act;
  logic rd_prev_r;
  logic rd_prev_nxt;
  logic wr_prev_r;
  logic wr_prev_nxt;
  logic rd_pulse_r;
  logic rd_pulse_nxt;
  logic wr_pulse_r;
  logic wr_pulse_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] wdata_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic link_irq_n_r;
  logic link_irq_n_nxt;
  logic rc_irq_n_r;
  logic rc_irq_n_nxt;
  logic aux_r;
  logic aux_nxt;
  logic shut_r;
  logic shut_nxt;
  logic rx_r;
  logic rx_nxt;

  assign suspend = !power_down_n_in;
  assign rd_act = !cs_n_in && !read_strobe_n_in && !suspend;
  assign wr_act = !cs_n_in && !write_strobe_n_in && !suspend;

  always_comb
  begin
    rd_prev_nxt = rd_act;
    wr_prev_nxt = wr_act;
    rd_pulse_nxt = rd_act && !rd_prev_r;
    wr_pulse_nxt = wr_act && !wr_prev_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    // read data captured once, at strobe entry
    if (rd_act && !rd_prev_r)
    begin
      addr_nxt = addr_in;
      rdata_nxt = reg_rdata_in;
    end
    if (wr_act && !wr_prev_r)
    begin
      addr_nxt = addr_in;
      wdata_nxt = data_in;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      rd_pulse_r <= 1'b0;
      wr_pulse_r <= 1'b0;
      addr_r <= ADDR_RESET;
      wdata_r <= RDATA_RESET;
      rdata_r <= RDATA_RESET;
    end
    else
    begin
      rd_prev_r <= rd_prev_nxt;
      wr_prev_r <= wr_prev_nxt;
      rd_pulse_r <= rd_pulse_nxt;
      wr_pulse_r <= wr_pulse_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rd_out = rd_pulse_r;
  assign reg_wr_out = wr_pulse_r;
  assign reg_addr_out = addr_r;
  assign reg_wdata_out = wdata_r;
  assign data_out = rdata_r;
  // drive data only during a read
  assign data_oe_out = rd_act && !reset_in;

  always_comb
  begin
    link_irq_n_nxt = !link_irq_cond_in;
    rc_irq_n_nxt = !remote_irq_cond_in;
    aux_nxt = suspend ? aux_r : aux_control_in;
    shut_nxt = suspend || !module_on_in;
    rx_nxt = suspend ? 1'b0 : ir_receive_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      link_irq_n_r <= IRQ_N_RESET_LVL;
      rc_irq_n_r <= IRQ_N_RESET_LVL;
      aux_r <= AUX_RESET_LVL;
      shut_r <= SHUTDOWN_RESET_LVL;
      rx_r <= 1'b0;
    end
    else
    begin
      link_irq_n_r <= link_irq_n_nxt;
      rc_irq_n_r <= rc_irq_n_nxt;
      aux_r <= aux_nxt;
      shut_r <= shut_nxt;
      rx_r <= rx_nxt;
    end
  end

  assign link_irq_n_out = link_irq_n_r;
  assign remote_irq_n_out = rc_irq_n_r;
  assign aux_control_out = aux_r;
  assign module_shutdown_out = shut_r;
  assign ir_receive_out = rx_r;
  assign wait_state_out = suspend;

  tx_route_if route ();
  assign route.remote_enable = remote_enable_in;
  assign route.remote_route_select = remote_route_select_in;
  assign route.passthrough_mode = passthrough_mode_in;
  assign route.link_sig = link_tx_in;
  assign route.remote_sig = remote_sig_in;
  assign route.ext_ir = external_ir_in;
  assign route.suspend = suspend;
  assign ir_transmit_out = route.ir_transmit;
  assign remote_tx_out = route.remote_tx;

  tx_router u_router (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .rt(route.router)
  );

  sequence rd_entry_s;
    !cs_n_in && !read_strobe_n_in && power_down_n_in && !rd_prev_r;
  endsequence
  sequence rd_answer_s;
    reg_rd_out && data_out == $past(reg_rdata_in);
  endsequence

  read_strobe_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    rd_entry_s |=> rd_answer_s)
    else $error("read entry did not give one strobe with captured data");
  write_cs_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    reg_wr_out |-> $past(!cs_n_in && !write_strobe_n_in) && !$past(reg_wr_out))
    else $error("write strobe without chip select or repeated");
  data_drive_a: assert property (@(posedge sys_clk_in)
    data_oe_out == (!cs_n_in && !read_strobe_n_in && power_down_n_in && !reset_in))
    else $error("data pins driven outside a read");
  link_irq_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    link_irq_cond_in |=> !link_irq_n_out)
    else $error("link interrupt pin not low on condition");
  remote_irq_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    remote_irq_cond_in && !link_irq_cond_in |=> !remote_irq_n_out && link_irq_n_out)
    else $error("remote interrupt pin not independent");
  power_wait_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !power_down_n_in [*2] |-> !reg_wr_out && !reg_rd_out && !ir_transmit_out && !remote_tx_out
      && wait_state_out)
    else $error("activity during power-down");
  reset_pins_a: assert property (@(posedge sys_clk_in)
    reset_in |=> !aux_control_out && module_shutdown_out && link_irq_n_out && remote_irq_n_out)
    else $error("pin levels wrong after reset");
  shutdown_ctl_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    power_down_n_in && module_on_in |=> !module_shutdown_out)
    else $error("transceiver kept shut down while enabled");
endmodule : ir_pin_port
`default_nettype wire

// *** sim/reg_store_model.sv ***
/*
  register store behind the pin port: reads answer from the address pins,
  writes land from the registered strobe outputs. assumes one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module reg_store_model (
  input wire logic sys_clk_in,
  input wire logic [ir_pin_pkg::BUS_ADDR_W-1:0] addr_in,
  input wire logic [ir_pin_pkg::BUS_ADDR_W-1:0] wr_addr_in,
  input wire logic [ir_pin_pkg::BUS_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  output logic [ir_pin_pkg::BUS_DATA_W-1:0] rdata_out
);
  import ir_pin_pkg::*;
  logic [BUS_DATA_W-1:0] mem [16];
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 16'h5a50 + 16'(i);
  end
  always @(posedge sys_clk_in)
    if (wr_in)
      mem[wr_addr_in] <= wdata_in;
  assign rdata_out = mem[addr_in];
endmodule : reg_store_model
`default_nettype wire

// *** sim/tb_top.sv ***
/*
  self-checking bench for the pin port: bus accesses, routing, pin copies,
  power-down and reset levels. assumes the register store model.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ir_pin_pkg::*;
  logic clk = 0, rst = 1, pd_n = 1, cs_n = 1, rd_n = 1, wr_n = 1;
  logic lc = 1, rcnd = 1, en = 0, rsel = 0, pt = 0, ltx = 1, rsig = 0;
  logic ext = 0, rx = 0, aux = 1, mon = 1;
  logic [3:0] addr = 4'h0;
  logic [3:0] raddr;
  logic [15:0] hd = 16'h0000;
  logic [15:0] dout, wdata, rdata;
  logic oe, wr_p, rd_p, lirq, rirq, rxo, txo, rco, auxo, shd, wst;
  wire logic [15:0] dpin;
  int num_errors = 0;
  int n_checks = 0;
  // shared data pins: device drives only while enabled
  assign dpin = oe ? dout : hd;
  ir_pin_port i_dut (.sys_clk_in(clk), .reset_in(rst), .power_down_n_in(pd_n),
    .cs_n_in(cs_n), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
    .addr_in(addr), .data_in(dpin), .data_out(dout), .data_oe_out(oe),
    .reg_addr_out(raddr), .reg_wdata_out(wdata), .reg_wr_out(wr_p),
    .reg_rd_out(rd_p), .reg_rdata_in(rdata), .link_irq_cond_in(lc),
    .remote_irq_cond_in(rcnd), .link_irq_n_out(lirq), .remote_irq_n_out(rirq),
    .remote_enable_in(en), .remote_route_select_in(rsel),
    .passthrough_mode_in(pt), .link_tx_in(ltx), .remote_sig_in(rsig),
    .external_ir_in(ext), .ir_receive_in(rx), .ir_receive_out(rxo),
    .ir_transmit_out(txo), .remote_tx_out(rco), .aux_control_in(aux),
    .aux_control_out(auxo), .module_on_in(mon), .module_shutdown_out(shd),
    .wait_state_out(wst));
  reg_store_model i_store (.sys_clk_in(clk), .addr_in(addr), .wr_addr_in(raddr),
    .wdata_in(wdata), .wr_in(wr_p), .rdata_out(rdata));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic stop_test;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // one host access; d is write data or expected read data
  task automatic acc(input logic c, input logic w, input logic [3:0] a,
                     input logic [15:0] d);
    logic ok;
    ok = !c && pd_n;
    @(posedge clk);
    cs_n <= c;
    wr_n <= !w;
    rd_n <= w;
    addr <= a;
    hd <= d;
    step(1);
    chk(w ? wr_p : rd_p, ok);
    chk(oe, ok && !w);
    if (ok)
    begin
      chk(raddr, a);
      chk(w ? wdata : dpin, d);
    end
    @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    #1;
    chk(oe, 1'b0);
    chk(w ? wr_p : rd_p, 1'b0);
  endtask : acc
  task automatic chk_rst;
    chk(txo, 1'b0);
    chk(rco, 1'b0);
    chk(lirq, 1'b1);
    chk(rirq, 1'b1);
    chk(auxo, 1'b0);
    chk(shd, 1'b1);
    chk(oe, 1'b0);
    chk({wr_p, rd_p}, 2'b00);
    chk(dout, 16'h0000);
  endtask : chk_rst
  task automatic t_bus;
    acc(1'b0, 1'b1, 4'h3, 16'h1234);
    acc(1'b0, 1'b1, 4'hf, 16'hffff);
    acc(1'b0, 1'b0, 4'h3, 16'h1234);
    acc(1'b0, 1'b0, 4'hf, 16'hffff);
    acc(1'b1, 1'b1, 4'h0, 16'h0000);
    acc(1'b1, 1'b0, 4'h0, 16'h5a50);
    acc(1'b0, 1'b0, 4'h0, 16'h5a50);
    $display("bus test done");
  endtask : t_bus
  task automatic t_route;
    for (int j = 0; j < 64; j++)
    begin
      logic [5:0] v;
      logic s;
      v = 6'(j);
      s = v[2] ? v[5] : (v[0] ? v[4] : v[3]);
      @(posedge clk);
      {ext, rsig, ltx, pt, rsel, en} <= v;
      step(2);
      chk(txo, (!v[0] || v[1]) && s);
      chk(rco, (v[0] && !v[1]) && s);
    end
    $display("route test done");
  endtask : t_route
  task automatic t_pins;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      lc <= k[0];
      rcnd <= k[1];
      rx <= k[0] ^ k[1];
      aux <= k[1];
      mon <= k[0];
      step(2);
      chk(lirq, !k[0]);
      chk(rirq, !k[1]);
      chk(rxo, k[0] ^ k[1]);
      chk(auxo, k[1]);
      chk(shd, !k[0]);
    end
    $display("pin test done");
  endtask : t_pins
  task automatic t_power_down;
    @(posedge clk);
    {ext, rsig, ltx, pt, rsel, en} <= 6'h08;
    lc <= 1'b1;
    aux <= 1'b1;
    mon <= 1'b1;
    step(2);
    chk(txo, 1'b1);
    @(posedge clk);
    pd_n <= 1'b0;
    step(2);
    chk(wst, 1'b1);
    chk(txo, 1'b0);
    chk(shd, 1'b1);
    acc(1'b0, 1'b1, 4'h5, 16'h0bad);
    @(posedge clk);
    rst <= 1'b1;
    pd_n <= 1'b1;
    step(4);
    chk_rst;
    chk(wst, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 1'b0, 4'h5, 16'h5a55);
    $display("power-down test done");
  endtask : t_power_down
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_rst;
    t_bus;
    t_route;
    t_pins;
    t_power_down;
    stop_test;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    num_errors++;
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
